// ===== design/cbt_bit_timing.sv
// bit-timing engine: segments, sample point, hard sync and resync
//
// Contract
// - quantum is 2*(prescale+1) module clocks
// - propagation segment 1..8 quanta, cfg two [2:0]
// - phase one 1..8 quanta, cfg two [5:3]
// - phase two programmed, else max(phase one, 2)
// - bus level sampled at phase one end
// - triple mode: majority of three, TQ/2 apart
// - cfg two bit 6 selects triple sampling
// - hard sync on idle falling edge only
// - no resync after hard sync same bit
// - edge position adjusts the two phase segments
// - adjustment bounded by jump width, cfg one [7:6]
// - prescale 0..63, module clock select
// - sync, prop, phase one, phase two order
`timescale 1ns/1ps
`include "cbt_params.svh"

module cbt_bit_timing (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_pin,
  input wire logic bus_idle,
  input wire logic module_clock_select,
  input wire logic [7:0] bit_timing_cfg_one,
  input wire logic [15:0] bit_timing_cfg_two,
  output cbt_pkg::cbt_timing_t timing
);

  logic rx_s;
  logic tq_tick;
  logic half_tick;
  logic restart_w;

  // rx pin passes two flip-flops before anything reads it
  cbt_sync2 u_rx_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(rx_pin),
    .dout(rx_s)
  );

  cbt_quantum_gen u_quantum (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(restart_w),
    .clk_sel(module_clock_select),
    .prescale(bit_timing_cfg_one[`CBT_PRESCALE_HI:`CBT_PRESCALE_LO]),
    .tq_tick(tq_tick),
    .half_tick(half_tick)
  );

  // decoded lengths in quanta; every field holds length minus one
  logic [`CBT_LEN_W-1:0] prop_seg_len;
  logic [`CBT_LEN_W-1:0] phase_one_len;
  logic [`CBT_LEN_W-1:0] phase_two_len;
  logic [`CBT_LEN_W-1:0] jump_width;
  logic triple_sample_sel;
  logic phase_two_prog;

  assign prop_seg_len = {2'h0, bit_timing_cfg_two[`CBT_PROP_HI:`CBT_PROP_LO]} + 5'h1;
  assign phase_one_len = {2'h0, bit_timing_cfg_two[`CBT_PH1_HI:`CBT_PH1_LO]} + 5'h1;
  assign jump_width = {3'h0, bit_timing_cfg_one[`CBT_JUMP_HI:`CBT_JUMP_LO]} + 5'h1;
  assign triple_sample_sel = bit_timing_cfg_two[`CBT_TRIPLE_BIT];
  assign phase_two_prog = bit_timing_cfg_two[`CBT_PH2_PROG_BIT];

  // phase two falls back to the larger of phase one and the processing time
  always_comb begin
    if (phase_two_prog) begin
      phase_two_len = {2'h0, bit_timing_cfg_two[`CBT_PH2_HI:`CBT_PH2_LO]} + 5'h1;
    end else if (phase_one_len > `CBT_PROC_TIME) begin
      phase_two_len = phase_one_len;
    end else begin
      phase_two_len = `CBT_PROC_TIME;
    end
  end

  function automatic logic [`CBT_LEN_W-1:0] lmin(
    input logic [`CBT_LEN_W-1:0] a,
    input logic [`CBT_LEN_W-1:0] b
  );
    lmin = (a < b) ? a : b;
  endfunction

  // bit-time state
  cbt_pkg::cbt_state_t state_r;
  cbt_pkg::cbt_state_t state_nxt;
  logic [`CBT_LEN_W-1:0] tq_cnt_r;
  logic [`CBT_LEN_W-1:0] tq_cnt_nxt;
  logic [`CBT_LEN_W-1:0] ph1_ext_r;
  logic [`CBT_LEN_W-1:0] ph1_ext_nxt;
  logic [`CBT_LEN_W-1:0] ph2_cut_r;
  logic [`CBT_LEN_W-1:0] ph2_cut_nxt;
  logic hs_done_r;
  logic hs_done_nxt;
  logic rs_done_r;
  logic rs_done_nxt;
  logic rx_prev_r;
  logic rx_prev_nxt;
  logic [1:0] hsamp_r;
  logic [1:0] hsamp_nxt;
  cbt_pkg::cbt_timing_t timing_r;
  cbt_pkg::cbt_timing_t timing_nxt;

  logic edge_w;
  logic hard_w;
  logic resync_w;
  logic maj_w;
  logic [`CBT_LEN_W-1:0] ph2_left_w;

  // only recessive-to-dominant edges are used for synchronisation
  assign edge_w = rx_prev_r & ~rx_s;
  assign hard_w = edge_w & bus_idle;
  // one resync per bit, and none in a bit that started by hard sync
  assign resync_w = edge_w & ~bus_idle & ~hs_done_r & ~rs_done_r;
  // samples one quantum and half a quantum before the sample point
  assign maj_w = (rx_s & hsamp_r[0]) | (rx_s & hsamp_r[1]) | (hsamp_r[0] & hsamp_r[1]);
  assign ph2_left_w = phase_two_len - tq_cnt_r;

  // next-state computation for the whole bit-time machine
  always_comb begin
    state_nxt = state_r;
    tq_cnt_nxt = tq_cnt_r;
    ph1_ext_nxt = ph1_ext_r;
    ph2_cut_nxt = ph2_cut_r;
    hs_done_nxt = hs_done_r;
    rs_done_nxt = rs_done_r;
    rx_prev_nxt = rx_s;
    hsamp_nxt = hsamp_r;
    timing_nxt = timing_r;
    timing_nxt.bit_start = 1'b0;
    timing_nxt.sample_strobe = 1'b0;
    timing_nxt.hard_synced = 1'b0;
    timing_nxt.resynced = 1'b0;
    restart_w = 1'b0;
    if (tq_tick || half_tick) begin
      hsamp_nxt = {hsamp_r[0], rx_s};
    end
    if (hard_w) begin
      // edge lands in the sync segment of a freshly restarted bit
      restart_w = 1'b1;
      state_nxt = cbt_pkg::seg_sync;
      tq_cnt_nxt = '0;
      ph1_ext_nxt = '0;
      ph2_cut_nxt = '0;
      hs_done_nxt = 1'b1;
      rs_done_nxt = 1'b1;
      timing_nxt.bit_start = 1'b1;
      timing_nxt.hard_synced = 1'b1;
    end else if (resync_w) begin
      rs_done_nxt = 1'b1;
      timing_nxt.resynced = 1'b1;
      case (state_r)
        cbt_pkg::seg_prop: begin
          // late edge: stretch phase one by the lag, capped at the jump width
          ph1_ext_nxt = lmin(tq_cnt_r + 5'h1, jump_width);
        end
        cbt_pkg::seg_ph1: begin
          ph1_ext_nxt = lmin(prop_seg_len + tq_cnt_r + 5'h1, jump_width);
        end
        cbt_pkg::seg_ph2: begin
          if (ph2_left_w <= jump_width) begin
            // early edge within reach: next bit starts on it
            restart_w = 1'b1;
            state_nxt = cbt_pkg::seg_sync;
            tq_cnt_nxt = '0;
            ph1_ext_nxt = '0;
            ph2_cut_nxt = '0;
            hs_done_nxt = 1'b0;
            timing_nxt.bit_start = 1'b1;
          end else begin
            ph2_cut_nxt = jump_width;
          end
        end
        default: begin
          // edge inside the sync segment carries no phase error
        end
      endcase
    end
    if (tq_tick && !restart_w) begin
      case (state_r)
        cbt_pkg::seg_sync: begin
          state_nxt = cbt_pkg::seg_prop;
          tq_cnt_nxt = '0;
        end
        cbt_pkg::seg_prop: begin
          if (tq_cnt_r == prop_seg_len - 5'h1) begin
            state_nxt = cbt_pkg::seg_ph1;
            tq_cnt_nxt = '0;
          end else begin
            tq_cnt_nxt = tq_cnt_r + 5'h1;
          end
        end
        cbt_pkg::seg_ph1: begin
          if (tq_cnt_r >= phase_one_len + ph1_ext_nxt - 5'h1) begin
            state_nxt = cbt_pkg::seg_ph2;
            tq_cnt_nxt = '0;
            timing_nxt.sample_strobe = 1'b1;
            timing_nxt.sample_bit = triple_sample_sel ? maj_w : rx_s;
          end else begin
            tq_cnt_nxt = tq_cnt_r + 5'h1;
          end
        end
        cbt_pkg::seg_ph2: begin
          if (tq_cnt_r >= phase_two_len - ph2_cut_nxt - 5'h1) begin
            state_nxt = cbt_pkg::seg_sync;
            tq_cnt_nxt = '0;
            ph1_ext_nxt = '0;
            ph2_cut_nxt = '0;
            hs_done_nxt = 1'b0;
            rs_done_nxt = 1'b0;
            timing_nxt.bit_start = 1'b1;
          end else begin
            tq_cnt_nxt = tq_cnt_r + 5'h1;
          end
        end
        default: begin
          state_nxt = cbt_pkg::seg_sync;
          tq_cnt_nxt = '0;
        end
      endcase
    end
  end

  // registers only; the bus is taken as idle-recessive after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= cbt_pkg::seg_sync;
      tq_cnt_r <= '0;
      ph1_ext_r <= '0;
      ph2_cut_r <= '0;
      hs_done_r <= 1'b0;
      rs_done_r <= 1'b0;
      rx_prev_r <= `CBT_RECESSIVE;
      hsamp_r <= {2{`CBT_RECESSIVE}};
      timing_r <= '{default: 1'b0, sample_bit: `CBT_RECESSIVE};
    end else begin
      state_r <= state_nxt;
      tq_cnt_r <= tq_cnt_nxt;
      ph1_ext_r <= ph1_ext_nxt;
      ph2_cut_r <= ph2_cut_nxt;
      hs_done_r <= hs_done_nxt;
      rs_done_r <= rs_done_nxt;
      rx_prev_r <= rx_prev_nxt;
      hsamp_r <= hsamp_nxt;
      timing_r <= timing_nxt;
    end
  end

  assign timing = timing_r;

  // checks kept beside the logic they guard
  property p_sync_one_tq;
    @(posedge clk_sys) disable iff (rst)
    (state_r == cbt_pkg::seg_sync && tq_tick && !edge_w) |=> (state_r == cbt_pkg::seg_prop);
  endproperty
  a_sync_one_tq: assert property (p_sync_one_tq)
    else $error("sync segment not left after one quantum");

  property p_prop_len;
    @(posedge clk_sys) disable iff (rst)
    (state_r == cbt_pkg::seg_prop && tq_tick && !edge_w && tq_cnt_r < prop_seg_len - 5'h1)
      |=> (state_r == cbt_pkg::seg_prop);
  endproperty
  a_prop_len: assert property (p_prop_len)
    else $error("propagation segment ended early");

  property p_ph1_end;
    @(posedge clk_sys) disable iff (rst)
    $rose(state_r == cbt_pkg::seg_ph2) |-> $past(tq_cnt_r) == phase_one_len + ph1_ext_r - 5'h1;
  endproperty
  a_ph1_end: assert property (p_ph1_end)
    else $error("phase one length wrong at sample point");

  property p_sample_point;
    @(posedge clk_sys) disable iff (rst)
    timing_r.sample_strobe |-> (state_r == cbt_pkg::seg_ph2 && tq_cnt_r == 5'h0);
  endproperty
  a_sample_point: assert property (p_sample_point)
    else $error("sample strobe not at phase one to phase two boundary");

  property p_single_sample;
    @(posedge clk_sys) disable iff (rst)
    (timing_r.sample_strobe && !$past(triple_sample_sel)) |-> timing_r.sample_bit == $past(rx_s);
  endproperty
  a_single_sample: assert property (p_single_sample)
    else $error("single sample does not match bus level");

  property p_triple_sample;
    @(posedge clk_sys) disable iff (rst)
    (timing_r.sample_strobe && $past(triple_sample_sel) && $past(hsamp_r[1]) == $past(hsamp_r[0]))
      |-> timing_r.sample_bit == $past(hsamp_r[0]);
  endproperty
  a_triple_sample: assert property (p_triple_sample)
    else $error("majority of three samples ignored");

  property p_hard_sync;
    @(posedge clk_sys) disable iff (rst)
    hard_w |=> (state_r == cbt_pkg::seg_sync && tq_cnt_r == 5'h0 && hs_done_r
      && timing_r.hard_synced && timing_r.bit_start);
  endproperty
  a_hard_sync: assert property (p_hard_sync)
    else $error("hard sync did not restart the bit");

  property p_no_resync;
    @(posedge clk_sys) disable iff (rst)
    hs_done_r |-> !timing_nxt.resynced;
  endproperty
  a_no_resync: assert property (p_no_resync)
    else $error("resync in a bit that was hard synchronised");

  property p_jump_bound;
    @(posedge clk_sys) disable iff (rst)
    $rose(timing_r.resynced) |-> (ph1_ext_r <= jump_width && ph2_cut_r <= jump_width);
  endproperty
  a_jump_bound: assert property (p_jump_bound)
    else $error("phase adjustment exceeds jump width");

  property p_ph2_min;
    @(posedge clk_sys) disable iff (rst)
    !phase_two_prog |-> (phase_two_len >= `CBT_PROC_TIME && phase_two_len >= phase_one_len);
  endproperty
  a_ph2_min: assert property (p_ph2_min)
    else $error("derived phase two shorter than allowed");

endmodule

// ===== pkg/cbt_params.svh
// constants for the bit-timing engine: field positions, widths and fixed lengths
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// first bit-timing configuration word
`define CBT_PRESCALE_HI 5
`define CBT_PRESCALE_LO 0
`define CBT_JUMP_HI 7
`define CBT_JUMP_LO 6

// second bit-timing configuration word
`define CBT_PROP_HI 2
`define CBT_PROP_LO 0
`define CBT_PH1_HI 5
`define CBT_PH1_LO 3
`define CBT_TRIPLE_BIT 6
`define CBT_PH2_PROG_BIT 7
`define CBT_PH2_HI 10
`define CBT_PH2_LO 8

// fixed lengths in quanta, and widths of the counters
`define CBT_SYNC_LEN 5'h1
`define CBT_PROC_TIME 5'h2
`define CBT_LEN_W 5
`define CBT_PRE_W 7
`define CBT_GAP_W 10

// module clock = clk_sys / 4 when the core clock is selected
`define CBT_CORE_DIV 2'h3
`define CBT_CORE_MUL 10'h4

// idle level of the bus line
`define CBT_RECESSIVE 1'b1

`endif

// ===== pkg/cbt_pkg.sv
// types shared by the bit-timing engine
package cbt_pkg;

  // the four segments of one nominal bit
  typedef enum logic [1:0] {
    seg_sync,
    seg_prop,
    seg_ph1,
    seg_ph2
  } cbt_state_t;

  // per-bit events and the sampled bit value
  typedef struct packed {
    logic bit_start;
    logic sample_strobe;
    logic sample_bit;
    logic hard_synced;
    logic resynced;
  } cbt_timing_t;

endpackage

// ===== design/cbt_sync2.sv
// two-flop synchroniser for the bus receive pin
`timescale 1ns/1ps
`include "cbt_params.svh"

module cbt_sync2 (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // meta_r feeds only sync_r
  always_comb begin
    meta_nxt = din;
    sync_nxt = meta_r;
  end

  // reset to recessive so no false edge is seen after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= `CBT_RECESSIVE;
      sync_r <= `CBT_RECESSIVE;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;

endmodule

// ===== design/cbt_quantum_gen.sv
// time-quantum generator: module clock select, fixed divide-by-two and prescaler
`timescale 1ns/1ps
`include "cbt_params.svh"

module cbt_quantum_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  input wire logic clk_sel,
  input wire logic [5:0] prescale,
  output logic tq_tick,
  output logic half_tick
);

  logic [1:0] pre_r;
  logic [1:0] pre_nxt;
  logic [`CBT_PRE_W-1:0] cnt_r;
  logic [`CBT_PRE_W-1:0] cnt_nxt;
  logic mod_en;
  logic [`CBT_PRE_W-1:0] top_w;

  // clk_sys stands for four times the core clock; select divides it back
  assign mod_en = clk_sel ? (pre_r == `CBT_CORE_DIV) : 1'b1;
  assign top_w = {prescale, 1'b1};
  assign tq_tick = mod_en && (cnt_r == top_w);
  assign half_tick = mod_en && (cnt_r == {1'b0, prescale});

  // restart realigns both dividers so a new quantum begins at once
  always_comb begin
    pre_nxt = pre_r + 2'h1;
    cnt_nxt = cnt_r;
    if (mod_en) begin
      cnt_nxt = (cnt_r == top_w) ? '0 : cnt_r + 7'h1;
    end
    if (restart) begin
      pre_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_r <= '0;
      cnt_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // helper: clk_sys cycles since the last quantum boundary
  logic [`CBT_GAP_W-1:0] gap_r;
  logic [`CBT_GAP_W-1:0] tq_cycles;
  assign tq_cycles = (clk_sel ? `CBT_CORE_MUL : 10'h1) * ({4'h0, prescale} + 10'h1) * 10'h2;
  always_ff @(posedge clk_sys) begin
    if (rst || restart || tq_tick) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 10'h1;
    end
  end

  property p_tq_period;
    @(posedge clk_sys) disable iff (rst)
    (tq_tick && !restart) |-> (gap_r == tq_cycles - 10'h1);
  endproperty
  a_tq_period: assert property (p_tq_period)
    else $error("quantum period differs from 2*(prescale+1) module clocks");

  property p_half_first;
    @(posedge clk_sys) disable iff (rst)
    (tq_tick && !restart) |-> !half_tick;
  endproperty
  a_half_first: assert property (p_half_first)
    else $error("half tick coincides with quantum tick");

endmodule

// ===== testbench/cbt_bus_node.sv
// far-side bus node model driving the receive line
`timescale 1ns/1ps
`include "cbt_params.svh"

module cbt_bus_node (
  output logic rx_line
);
  logic dom_req = 1'b0;

  // released line floats back to the recessive pull-up level, never holds a stale 0
  assign rx_line = dom_req ? 1'b0 : `CBT_RECESSIVE;

  // 0 pulls the line dominant, 1 releases it; caller times it just after a clock edge
  task automatic drive(input logic lvl);
    dom_req = ~lvl;
  endtask
endmodule

// ===== testbench/test_cbt_bit_timing.sv
// self-checking bench for the bit-timing engine
`timescale 1ns/1ps
`include "cbt_params.svh"

module test_cbt_bit_timing;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rx_pin;
  logic bus_idle;
  logic module_clock_select;
  logic [7:0] bit_timing_cfg_one;
  logic [15:0] bit_timing_cfg_two;
  cbt_pkg::cbt_timing_t timing;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int s_off;
  int b_len;
  int n_res;
  int n_hard;
  int tq;
  logic smp;
  logic hs0;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  cbt_bit_timing dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .rx_pin(rx_pin),
    .bus_idle(bus_idle),
    .module_clock_select(module_clock_select),
    .bit_timing_cfg_one(bit_timing_cfg_one),
    .bit_timing_cfg_two(bit_timing_cfg_two),
    .timing(timing)
  );

  cbt_bus_node node (
    .rx_line(rx_pin)
  );

  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  // hang guard: whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // config is only legal while the engine is held, so every change goes under reset
  task automatic set_cfg(input int sel, pre, jw, prop, ph1, ph2, prog, trip, idle);
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    module_clock_select = sel[0];
    bus_idle = idle[0];
    bit_timing_cfg_one = {2'(jw - 1), 6'(pre)};
    bit_timing_cfg_two = {5'h00, 3'(ph2 - 1), prog[0], trip[0], 3'(ph1 - 1), 3'(prop - 1)};
    node.drive(1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    tq = (sel != 0 ? 4 : 1) * 2 * (pre + 1);
  endtask

  // waits for a bit start, then follows that bit to the next start;
  // f and r are cycle offsets at which the far node pulls or releases the line (0 = none)
  task automatic measure(input int f1, r1, f2, r2);
    int guard;
    guard = 0;
    n_res = 0;
    n_hard = 0;
    s_off = -1;
    b_len = -1;
    smp = 1'bx;
    while (timing.bit_start !== 1'b1 && guard < 4000) begin
      @(posedge clk_sys);
      #1;
      guard++;
    end
    check("bit start seen", timing.bit_start, 1'b1);
    hs0 = timing.hard_synced;
    bus_idle = 1'b0;
    for (int i = 1; i < 3000 && b_len < 0; i++) begin
      @(posedge clk_sys);
      #1;
      if (timing.sample_strobe === 1'b1) begin
        s_off = i;
        smp = timing.sample_bit;
      end
      if (timing.resynced === 1'b1) n_res++;
      if (timing.hard_synced === 1'b1) n_hard++;
      if (timing.bit_start === 1'b1) b_len = i;
      if (i == f1 || i == f2) node.drive(1'b0);
      if (i == r1 || i == r2) node.drive(1'b1);
    end
  endtask

  // quiet recessive line: segment lengths, order and sample point
  task automatic run_free(input int sel, pre, prop, ph1, ph2, prog);
    int p2;
    p2 = prog != 0 ? ph2 : (ph1 > 2 ? ph1 : 2);
    set_cfg(sel, pre, 1, prop, ph1, ph2, prog, 0, 0);
    measure(0, 0, 0, 0);
    check("sample offset", s_off, (1 + prop + ph1) * tq);
    check("bit length", b_len, (1 + prop + ph1 + p2) * tq);
    check("recessive sample", smp, 1'b1);
    check("quiet resync count", n_res, 0);
  endtask

  initial begin
    // defined levels during the opening reset; set_cfg replaces them per scenario
    bus_idle = 1'b0;
    module_clock_select = 1'b0;
    bit_timing_cfg_one = 8'h00;
    bit_timing_cfg_two = 16'h0000;
    node.drive(1'b1);
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // every config keeps 8..25 quanta, prop+ph1 >= ph2 and jump below ph2
    run_free(0, 0, 1, 4, 2, 1);
    run_free(0, 1, 8, 8, 8, 1);
    run_free(0, 0, 6, 1, 1, 0);
    // sample point at 8 of 13 quanta, inside the advised band
    run_free(0, 2, 2, 5, 1, 0);
    run_free(1, 0, 3, 2, 2, 1);
    run_free(0, 63, 2, 3, 2, 1);
    // late edge three quanta after sync: phase one grows by min(3, jump width)
    for (int j = 1; j <= 4; j++) begin
      set_cfg(0, 1, j, 4, 4, 5, 1, 0, 0);
      measure(10, 0, 0, 0);
      node.drive(1'b1);
      check("resync sample offset", s_off, (9 + (j < 3 ? j : 3)) * tq);
      check("resync count", n_res, 1);
      check("busy edge hard sync", n_hard + int'(hs0), 0);
      check("dominant sample", smp, 1'b0);
    end
    // early edge in phase two: far from its end phase two loses the jump width;
    // within the jump width of its end the next bit starts on the edge
    // (edge seen two synchroniser cycles plus one detect after the pull, bit starts next edge)
    for (int e = 0; e < 2; e++) begin
      set_cfg(0, 1, 2, 4, 4, 5, 1, 0, 0);
      measure(e != 0 ? 47 : 39, 0, 0, 0);
      node.drive(1'b1);
      check("early bit length", b_len, e != 0 ? 47 + 3 : (14 - 2) * tq);
      check("early resync count", n_res, 1);
      check("early edge sample", smp, 1'b1);
    end
    // idle edge hard-syncs; a second edge in that bit must not resync;
    // line returns recessive just before the sample point, so only triple mode sees dominant
    for (int t = 0; t < 2; t++) begin
      set_cfg(0, 3, 1, 2, 3, 3, 1, t, 1);
      repeat (20) @(posedge clk_sys);
      #1;
      node.drive(1'b0);
      measure(30, 20, 0, 42);
      check("hard sync flag", hs0, 1'b1);
      check("resync after hard sync", n_res + n_hard, 0);
      check("hard sync sample offset", s_off, 6 * tq);
      check("majority sample", smp, t != 0 ? 1'b0 : 1'b1);
    end
    print_verdict();
  end
endmodule
